// file: src/fsr_status_top.sv
// Purpose: First status register of a serial flash, with its SPI command handling.
// Assumes: SPI mode 0 host; SCK well below a quarter of the core clock.
// Notes: Program and erase arrive from the main decoder as complete requests.

`timescale 1ns/100ps

module fsr_status_top #(
    parameter int NV_WRITE_CYC = fsr_pkg::FSR_NV_WRITE_CYC
) (
    input wire logic core_clk_in,
    input wire logic arst_n_in,
    input wire logic spi_cs_n_in,
    input wire logic spi_sck_in,
    input wire logic spi_si_in,
    output logic spi_so_out,
    output logic spi_so_oe_n_out,
    input wire logic wp_n_in,
    input wire logic status_protect_bit_b_in,
    input wire logic mem_req_valid_in,
    input wire fsr_pkg::fsr_mem_req_t mem_req_in,
    input wire logic mem_done_in,
    input wire logic mem_abort_in,
    output logic mem_accept_out,
    output logic mem_reject_out,
    output fsr_pkg::fsr_status_t status_out,
    output fsr_pkg::fsr_scheme_t scheme_out,
    output logic [7:0] nv_copy_out,
    output logic nv_write_active_out
);
    // ==========================================================================
    // Reset release and pin synchronisers
    // ==========================================================================
    logic rst_s1_r, rst_n_r;
    logic [3:0] pin_s1_r, pin_s2_r;
    logic sck_d_r, cs_d_r;

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_s1_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n_r <= rst_s1_r;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            pin_s1_r <= fsr_pkg::FSR_PIN_RST;
            pin_s2_r <= fsr_pkg::FSR_PIN_RST;
            sck_d_r <= 1'b0;
            cs_d_r <= 1'b1;
        end else begin
            pin_s1_r <= {wp_n_in, spi_cs_n_in, spi_sck_in, spi_si_in};
            pin_s2_r <= pin_s1_r;
            sck_d_r <= pin_s2_r[1];
            cs_d_r <= pin_s2_r[2];
        end
    end

    wire wp_n_s = pin_s2_r[3];
    wire cs_n_s = pin_s2_r[2];
    wire sck_s = pin_s2_r[1];
    wire si_s = pin_s2_r[0];
    wire sel = !cs_n_s;
    wire sck_rise = sel && sck_s && !sck_d_r;
    wire sck_fall = sel && !sck_s && sck_d_r;
    wire cs_rise = cs_n_s && !cs_d_r;

    // ==========================================================================
    // SPI frame tracking
    // ==========================================================================
    fsr_pkg::fsr_spi_st_t st_r, st_nxt;
    logic [2:0] bitpos_r;
    logic [1:0] byte_cnt_r;
    logic [7:0] shift_in_r, opcode_r, data_r;
    logic [6:0] so_sh_r;
    logic so_r;

    wire byte_done = sck_rise && (bitpos_r == 3'h7);
    wire [7:0] rx_byte = {shift_in_r[6:0], si_s};
    wire frame8 = (byte_cnt_r == 2'h1) && (bitpos_r == 3'h0);
    wire frame16 = (byte_cnt_r == 2'h2) && (bitpos_r == 3'h0);
    wire [1:0] byte_cnt_inc = (byte_cnt_r == 2'h3) ? byte_cnt_r : byte_cnt_r + 2'h1;
    fsr_pkg::fsr_spi_st_t cmd_st;
    assign cmd_st = (rx_byte == fsr_pkg::FSR_OP_WRSR) ? fsr_pkg::FSR_ST_WDATA
        : ((rx_byte == fsr_pkg::FSR_OP_RDSR) ? fsr_pkg::FSR_ST_READ : fsr_pkg::FSR_ST_SKIP);

    always_comb begin
        st_nxt = st_r;
        if (!sel) begin
            st_nxt = fsr_pkg::FSR_ST_CMD;
        end else if (byte_done) begin
            unique case (st_r)
                fsr_pkg::FSR_ST_CMD: st_nxt = cmd_st;
                fsr_pkg::FSR_ST_WDATA: st_nxt = fsr_pkg::FSR_ST_SKIP;
                fsr_pkg::FSR_ST_READ: st_nxt = fsr_pkg::FSR_ST_READ;
                fsr_pkg::FSR_ST_SKIP: st_nxt = fsr_pkg::FSR_ST_SKIP;
            endcase
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            st_r <= fsr_pkg::FSR_ST_CMD;
            bitpos_r <= 3'h0;
            byte_cnt_r <= 2'h0;
            shift_in_r <= 8'h00;
        end else begin
            st_r <= st_nxt;
            if (!sel) begin
                bitpos_r <= 3'h0;
                byte_cnt_r <= 2'h0;
            end else if (sck_rise) begin
                shift_in_r <= rx_byte;
                bitpos_r <= bitpos_r + 3'h1;
                byte_cnt_r <= byte_done ? byte_cnt_inc : byte_cnt_r;
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            opcode_r <= 8'h00;
            data_r <= 8'h00;
        end else if (byte_done) begin
            opcode_r <= (byte_cnt_r == 2'h0) ? rx_byte : opcode_r;
            data_r <= (byte_cnt_r == 2'h1) ? rx_byte : data_r;
        end
    end

    // ==========================================================================
    // Status fields and write control
    // ==========================================================================
    logic prot_a_r, gran_r, dir_r, wel_r, vwren_r, mem_busy_r, nv_busy_r;
    logic [2:0] range_r;
    logic [31:0] nv_cnt_r;
    logic [7:0] nv_copy_r, nv_pend_r;
    logic prot_hit;
    fsr_pkg::fsr_status_t status_w;
    fsr_pkg::fsr_scheme_t scheme_w;

    // Busy covers array and non-volatile work.
    wire busy = mem_busy_r || nv_busy_r;
    assign scheme_w = fsr_pkg::fsr_scheme_t'({status_protect_bit_b_in, prot_a_r});
    wire sr_locked = (scheme_w == fsr_pkg::FSR_SCHEME_HW) ? !wp_n_s
        : (scheme_w != fsr_pkg::FSR_SCHEME_SW);
    // Write enable executes on a clean 8-bit frame.
    wire exec_wren = cs_rise && frame8 && (opcode_r == fsr_pkg::FSR_OP_WREN) && !busy;
    wire exec_vwren = cs_rise && frame8 && (opcode_r == fsr_pkg::FSR_OP_VWREN) && !busy;
    wire wrsr_full = cs_rise && frame16 && (opcode_r == fsr_pkg::FSR_OP_WRSR) && !busy;
    wire wrsr_enabled = wel_r || vwren_r;
    wire wrsr_ok = wrsr_full && wrsr_enabled && !sr_locked;
    wire wrsr_refused = wrsr_full && wrsr_enabled && sr_locked;
    // Latch path also commits the non-volatile copy.
    wire wrsr_nv = wrsr_ok && wel_r;
    wire nv_done = nv_busy_r && (nv_cnt_r == 32'h0);
    fsr_prot_check u_prot (
        .protect_granule_select_in(gran_r),
        .protect_direction_select_in(dir_r),
        .protect_range_field_in(range_r),
        .req_in(mem_req_in),
        .hit_out(prot_hit)
    );
    wire mem_try = mem_req_valid_in && !busy;
    wire mem_prot_rej = mem_try && wel_r && prot_hit;
    assign mem_accept_out = mem_try && wel_r && !prot_hit;
    assign mem_reject_out = mem_req_valid_in && !mem_accept_out;
    wire mem_end = mem_busy_r && (mem_done_in || mem_abort_in);
    // Complete commands that end or abort clear the latch.
    // Completion requires a fresh write enable.
    wire wel_clear = mem_end || nv_done || mem_prot_rej || wrsr_refused;
    // Incomplete frames are not among the clear terms.
    // Volatile enable never sets the latch.
    wire wel_nxt = exec_wren ? 1'b1 : (wel_clear ? 1'b0 : wel_r);
    wire vwren_nxt = exec_vwren ? 1'b1 : ((exec_wren || wrsr_full) ? 1'b0 : vwren_r);
    wire [31:0] nv_cnt_nxt = wrsr_nv ? 32'(NV_WRITE_CYC - 1)
        : (nv_busy_r ? nv_cnt_r - 32'h1 : nv_cnt_r);
    // Reset returns every field to default.
    always_ff @(posedge core_clk_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            wel_r <= 1'b0;
            vwren_r <= 1'b0;
            mem_busy_r <= 1'b0;
            nv_busy_r <= 1'b0;
            nv_cnt_r <= 32'h0;
        end else begin
            wel_r <= wel_nxt;
            vwren_r <= vwren_nxt;
            mem_busy_r <= mem_accept_out || (mem_busy_r && !mem_end);
            nv_busy_r <= wrsr_nv || (nv_busy_r && !nv_done);
            nv_cnt_r <= nv_cnt_nxt;
        end
    end
    // Range field defaults to nothing protected.
    // Accepted status write loads the writable bits.
    always_ff @(posedge core_clk_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            {prot_a_r, gran_r, dir_r} <= 3'h0;
            range_r <= fsr_pkg::FSR_RANGE_RST;
        end else if (wrsr_ok) begin
            prot_a_r <= data_r[fsr_pkg::FSR_BIT_PROT_A];
            gran_r <= data_r[fsr_pkg::FSR_BIT_GRAN];
            dir_r <= data_r[fsr_pkg::FSR_BIT_DIR];
            range_r <= data_r[fsr_pkg::FSR_BIT_RANGE_HI:fsr_pkg::FSR_BIT_RANGE_LO];
        end
    end
    always_ff @(posedge core_clk_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            nv_pend_r <= fsr_pkg::FSR_STATUS_RST;
            nv_copy_r <= fsr_pkg::FSR_STATUS_RST;
        end else begin
            nv_pend_r <= wrsr_nv ? {data_r[7:2], 2'b00} : nv_pend_r;
            nv_copy_r <= nv_done ? nv_pend_r : nv_copy_r;
        end
    end

    // ==========================================================================
    // Status read-out
    // ==========================================================================
    assign status_w = '{prot_a_r, gran_r, dir_r, range_r, wel_r, busy};
    wire so_load = sck_fall && (st_r == fsr_pkg::FSR_ST_READ) && (bitpos_r == 3'h0);
    always_ff @(posedge core_clk_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            so_r <= 1'b0;
            so_sh_r <= 7'h00;
        end else if (so_load) begin
            {so_r, so_sh_r} <= status_w;
        end else if (sck_fall && (st_r == fsr_pkg::FSR_ST_READ)) begin
            so_r <= so_sh_r[6];
            so_sh_r <= {so_sh_r[5:0], 1'b0};
        end
    end

    assign spi_so_out = so_r;
    assign spi_so_oe_n_out = !(sel && (st_r == fsr_pkg::FSR_ST_READ));
    assign status_out = status_w;
    assign scheme_out = scheme_w;
    assign nv_copy_out = nv_copy_r;
    assign nv_write_active_out = nv_busy_r;

    // ==========================================================================
    // Assertions
    // ==========================================================================
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_r);
    wire [2:0] wr_range = data_r[fsr_pkg::FSR_BIT_RANGE_HI:fsr_pkg::FSR_BIT_RANGE_LO];
    a_wren_sets_wel: assert property (exec_wren |=> wel_r)
        else $error("write enable did not set the latch");
    a_vwren_no_wel: assert property (exec_vwren && !wel_r |=> !wel_r)
        else $error("volatile enable set the latch");
    a_accept_needs_wel: assert property (mem_accept_out |-> wel_r && !busy)
        else $error("operation accepted without the latch");
    a_prot_refused: assert property (mem_prot_rej |-> mem_reject_out ##1 !wel_r)
        else $error("protected operation not refused");
    a_busy_follows: assert property (mem_accept_out |=> status_out.busy_flag [*2])
        else $error("busy did not follow an accepted operation");
    a_done_clears_wel: assert property (mem_end |=> !wel_r && !mem_busy_r)
        else $error("completion left the latch set");
    a_partial_keeps: assert property (cs_rise && wel_r && !frame16 && !busy
        && !mem_req_valid_in |=> wel_r)
        else $error("incomplete frame cleared the latch");
    a_locked_clears: assert property (wrsr_refused |=> !wel_r && $stable(range_r))
        else $error("refused status write kept the latch");
    a_wrsr_range: assert property (wrsr_ok |=> range_r == $past(wr_range))
        else $error("status write did not load the range");
    a_nv_path: assert property (wrsr_ok |=> nv_busy_r == $past(wel_r))
        else $error("wrong status write path");
    a_read_fresh: assert property (so_load |=> spi_so_out == $past(prot_a_r))
        else $error("read byte not loaded from live status");

    c_wren: cover property (exec_wren);
    c_nv_write: cover property (wrsr_nv);
    c_prot_reject: cover property (mem_prot_rej);
    c_poll_two: cover property (so_load ##[1:200] so_load);

endmodule

// file: common/fsr_pkg.sv
// Purpose: Shared constants and types for the first flash status register block.
// Assumes: 100 MHz core clock; SPI pins are oversampled by that clock.
// Notes: Bit positions, opcodes, reset values and timing counts live here only.

package fsr_pkg;

    // ==========================================================================
    // Clock and timing
    // ==========================================================================
    localparam int FSR_CLK_PERIOD_NS = 10;
    // Non-volatile status write time in microseconds; a plain default.
    localparam int FSR_NV_WRITE_US = 1000;
    localparam int FSR_NV_WRITE_CYC = (FSR_NV_WRITE_US * 1000) / FSR_CLK_PERIOD_NS;

    // ==========================================================================
    // Opcodes
    // ==========================================================================
    localparam logic [7:0] FSR_OP_WRSR = 8'h01;
    localparam logic [7:0] FSR_OP_RDSR = 8'h05;
    localparam logic [7:0] FSR_OP_WREN = 8'h06;
    localparam logic [7:0] FSR_OP_VWREN = 8'h50;

    // ==========================================================================
    // Register layout and reset values
    // ==========================================================================
    localparam int FSR_BIT_PROT_A = 7;
    localparam int FSR_BIT_GRAN = 6;
    localparam int FSR_BIT_DIR = 5;
    localparam int FSR_BIT_RANGE_HI = 4;
    localparam int FSR_BIT_RANGE_LO = 2;
    localparam int FSR_BIT_WEL = 1;
    localparam int FSR_BIT_BUSY = 0;
    localparam logic [7:0] FSR_STATUS_RST = 8'h00;
    localparam logic [2:0] FSR_RANGE_RST = 3'h0;
    localparam logic [2:0] FSR_RANGE_ALL = 3'h7;
    // Synchronised pin reset order {wp_n, cs_n, sck, si}.
    localparam logic [3:0] FSR_PIN_RST = 4'hC;

    // ==========================================================================
    // Array geometry
    // ==========================================================================
    localparam int FSR_ADDR_W = 19;
    localparam int FSR_GRAN_SMALL_SH = 12;
    localparam int FSR_GRAN_LARGE_SH = 16;

    // ==========================================================================
    // Types
    // ==========================================================================
    typedef enum logic [1:0] {
        FSR_SCHEME_SW = 2'b00,
        FSR_SCHEME_HW = 2'b01,
        FSR_SCHEME_LOCK = 2'b10,
        FSR_SCHEME_OTP = 2'b11
    } fsr_scheme_t;

    typedef enum logic [1:0] {
        FSR_ST_CMD = 2'b00,
        FSR_ST_WDATA = 2'b01,
        FSR_ST_READ = 2'b10,
        FSR_ST_SKIP = 2'b11
    } fsr_spi_st_t;

    typedef struct packed {
        logic [FSR_ADDR_W-1:0] first;
        logic [FSR_ADDR_W-1:0] last;
    } fsr_mem_req_t;

    typedef struct packed {
        logic status_protect_bit_a;
        logic protect_granule_select;
        logic protect_direction_select;
        logic [2:0] protect_range_field;
        logic write_enable_latch;
        logic busy_flag;
    } fsr_status_t;

endpackage

// file: src/fsr_prot_check.sv
// Purpose: Decides whether a memory operation touches the protected span.
// Assumes: Requests give an inclusive first and last byte address.
// Notes: Range code 0 protects nothing, 7 protects all, n doubles the block count.

`timescale 1ns/100ps

module fsr_prot_check (
    input wire logic protect_granule_select_in,
    input wire logic protect_direction_select_in,
    input wire logic [2:0] protect_range_field_in,
    input wire fsr_pkg::fsr_mem_req_t req_in,
    output logic hit_out
);
    localparam int AW = fsr_pkg::FSR_ADDR_W;
    localparam logic [AW:0] ARRAY_BYTES = (AW+1)'(1) << AW;

    wire [AW:0] blocks = (AW+1)'(1) << (protect_range_field_in - 3'h1);
    wire [AW:0] small_len = blocks << fsr_pkg::FSR_GRAN_SMALL_SH;
    wire [AW:0] large_len = blocks << fsr_pkg::FSR_GRAN_LARGE_SH;
    wire [AW:0] raw_len = protect_granule_select_in ? small_len : large_len;
    wire whole = (protect_range_field_in == fsr_pkg::FSR_RANGE_ALL) || (raw_len >= ARRAY_BYTES)
        || (raw_len == '0);
    wire [AW:0] span_len = whole ? ARRAY_BYTES : raw_len;
    wire [AW:0] prot_lo = protect_direction_select_in ? (ARRAY_BYTES - span_len) : '0;
    wire [AW:0] prot_hi = protect_direction_select_in ? (ARRAY_BYTES - (AW+1)'(1))
        : (span_len - (AW+1)'(1));
    wire any_prot = (protect_range_field_in != fsr_pkg::FSR_RANGE_RST);

    assign hit_out = any_prot && ({1'b0, req_in.first} <= prot_hi)
        && ({1'b0, req_in.last} >= prot_lo);

endmodule

// file: test/fsr_spi_host.sv
// Purpose: SPI mode 0 host model that frames commands and collects read bytes.
// Assumes: Every SCK phase and the chip-select set-up last six core cycles.
// Notes: SI toggles when no bit is due, so a stale level never looks like data.

`timescale 1ns/100ps

module fsr_spi_host (
    input wire logic clk_in,
    output logic cs_n_out,
    output logic sck_out,
    output logic si_out,
    input wire logic so_in,
    output logic [7:0] rx_byte_out,
    output int rx_cnt_out
);
    // ==========================================================================
    // Framing
    // ==========================================================================
    initial begin
        cs_n_out = 1'b1;
        sck_out = 1'b0;
        si_out = 1'b0;
        rx_byte_out = 8'h00;
        rx_cnt_out = 0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask

    task automatic xfer(input logic [15:0] tx, input int ntx, input int nrx);
        logic [7:0] b;
        b = 8'h00;
        cs_n_out <= 1'b0;
        tick(6);
        for (int i = 0; i < ntx + 8 * nrx; i++) begin
            si_out <= (i < ntx) ? tx[15 - i] : ~si_out;
            tick(6);
            sck_out <= 1'b1;
            b = {b[6:0], so_in};
            tick(6);
            sck_out <= 1'b0;
            if (i >= ntx && (i - ntx) % 8 == 7) begin
                rx_byte_out <= b;
                rx_cnt_out <= rx_cnt_out + 1;
            end
        end
        tick(6);
        cs_n_out <= 1'b1;
        si_out <= ~si_out;
        tick(12);
    endtask
endmodule

// file: test/tb_fsr_status_top.sv
// Purpose: Self-checking bench for the first flash status register block.
// Assumes: Short non-volatile write time so polling sees busy end.
// Notes: Read bytes and memory answers are checked against queued notes.

`timescale 1ns/100ps

module tb_fsr_status_top;
    logic core_clk_in, arst_n_in, wp_n_in, bit_b, req_v, done, abort;
    logic cs_n, sck, si, so, so_oe_n, acc, rej, nva;
    logic [7:0] nvc, rxb, lf;
    fsr_pkg::fsr_mem_req_t req;
    fsr_pkg::fsr_status_t st;
    fsr_pkg::fsr_scheme_t sch;
    // A released SO line shows the inverse of the last bit, so a late enable is caught.
    wire so_pin = so_oe_n ? ~so : so;
    int rxc, seen, num_errors, compares;
    logic [7:0] spi_q[$];
    logic mem_q[$];
    logic [7:0] t_sr[8] = '{8'h64, 8'h64, 8'h44, 8'h44, 8'h24, 8'h24, 8'h1C, 8'h00};
    logic [18:0] t_a[8] = '{19'h7EFFF, 19'h7F000, 19'h01000, 19'h00FFF,
                            19'h6FFFF, 19'h70000, 19'h00000, 19'h40000};
    logic t_e[8] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
    logic t_ab[8] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};

    fsr_status_top #(.NV_WRITE_CYC(250)) uut (.core_clk_in(core_clk_in),
        .arst_n_in(arst_n_in), .spi_cs_n_in(cs_n), .spi_sck_in(sck), .spi_si_in(si),
        .spi_so_out(so), .spi_so_oe_n_out(so_oe_n), .wp_n_in(wp_n_in),
        .status_protect_bit_b_in(bit_b), .mem_req_valid_in(req_v), .mem_req_in(req),
        .mem_done_in(done), .mem_abort_in(abort), .mem_accept_out(acc),
        .mem_reject_out(rej), .status_out(st), .scheme_out(sch), .nv_copy_out(nvc),
        .nv_write_active_out(nva));
    fsr_spi_host host (.clk_in(core_clk_in), .cs_n_out(cs_n), .sck_out(sck), .si_out(si),
        .so_in(so_pin), .rx_byte_out(rxb), .rx_cnt_out(rxc));

    // ==========================================================================
    // Checking
    // ==========================================================================
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic complete_run;
        num_errors += spi_q.size() + mem_q.size();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    always @(posedge core_clk_in) begin
        logic e;
        if (rxc != seen) begin
            seen <= rxc;
            chk(rxb, spi_q.size() ? spi_q.pop_front() : 8'hXX);
            chk({7'h00, so_oe_n}, 8'h00);
        end
        if (req_v) begin
            e = mem_q.size() ? mem_q.pop_front() : 1'bx;
            chk({6'h00, acc, rej}, {6'h00, e, ~e});
        end
    end

    // ==========================================================================
    // Stimulus
    // ==========================================================================
    task automatic cmd(input logic [7:0] op, input logic [7:0] d, input int n);
        host.xfer({op, d}, n, 0);
    endtask

    task automatic rd(input logic [7:0] e);
        spi_q.push_back(e);
        host.xfer({fsr_pkg::FSR_OP_RDSR, 8'h00}, 8, 1);
    endtask

    task automatic mem(input logic [18:0] a, input logic e, input logic ab);
        @(posedge core_clk_in);
        mem_q.push_back(e);
        req_v <= 1'b1;
        req <= '{first: a, last: a};
        @(posedge core_clk_in);
        req_v <= 1'b0;
        if (e) begin
            @(posedge core_clk_in);
            chk({7'h00, st.busy_flag}, 8'h01);
            if (ab) abort <= 1'b1;
            else done <= 1'b1;
            @(posedge core_clk_in);
            abort <= 1'b0;
            done <= 1'b0;
            repeat (2) @(posedge core_clk_in);
            chk({7'h00, st.busy_flag}, 8'h00);
        end
    endtask

    initial begin
        core_clk_in = 1'b0;
        forever #5 core_clk_in = ~core_clk_in;
    end

    initial begin
        repeat (60000) @(posedge core_clk_in);
        num_errors++;
        complete_run();
    end

    initial begin
        arst_n_in = 1'b0;
        {wp_n_in, bit_b, req_v, done, abort} = 5'h10;
        req = '0;
        seen = 0;
        lf = 8'h4D;
        repeat (6) @(posedge core_clk_in);
        arst_n_in <= 1'b1;
        repeat (8) @(posedge core_clk_in);
        chk(st, 8'h00);
        chk({7'h00, so_oe_n}, 8'h01);
        rd(8'h00);
        mem(19'h00000, 1'b0, 1'b0);
        cmd(fsr_pkg::FSR_OP_WRSR, 8'hFC, 16);
        rd(8'h00);
        cmd(fsr_pkg::FSR_OP_VWREN, 8'h00, 8);
        rd(8'h00);
        lf = lfsr(lf);
        cmd(fsr_pkg::FSR_OP_WRSR, lf, 16);
        rd(lf & 8'hFC);
        chk(nvc, 8'h00);
        chk({6'h00, sch}, {6'h00, bit_b, lf[7]});
        cmd(fsr_pkg::FSR_OP_WREN, 8'h00, 8);
        rd((lf & 8'hFC) | 8'h02);
        cmd(8'hA5, 8'h00, 8);
        cmd(fsr_pkg::FSR_OP_WRSR, 8'h00, 12);
        rd((lf & 8'hFC) | 8'h02);
        lf = lfsr(lf);
        cmd(fsr_pkg::FSR_OP_WRSR, lf, 16);
        chk({7'h00, nva}, 8'h01);
        spi_q.push_back(lf | 8'h03);
        spi_q.push_back(lf | 8'h03);
        spi_q.push_back(lf & 8'hFC);
        spi_q.push_back(lf & 8'hFC);
        host.xfer({fsr_pkg::FSR_OP_RDSR, 8'h00}, 8, 4);
        chk(nvc, lf & 8'hFC);
        chk({7'h00, nva}, 8'h00);
        cmd(fsr_pkg::FSR_OP_VWREN, 8'h00, 8);
        cmd(fsr_pkg::FSR_OP_WRSR, 8'h80, 16);
        wp_n_in <= 1'b0;
        cmd(fsr_pkg::FSR_OP_WREN, 8'h00, 8);
        cmd(fsr_pkg::FSR_OP_WRSR, 8'h00, 16);
        rd(8'h80);
        bit_b <= 1'b1;
        repeat (4) @(posedge core_clk_in);
        chk({6'h00, sch}, {6'h00, fsr_pkg::FSR_SCHEME_OTP});
        bit_b <= 1'b0;
        wp_n_in <= 1'b1;
        repeat (4) @(posedge core_clk_in);
        for (int i = 0; i < 8; i++) begin
            cmd(fsr_pkg::FSR_OP_VWREN, 8'h00, 8);
            cmd(fsr_pkg::FSR_OP_WRSR, t_sr[i], 16);
            cmd(fsr_pkg::FSR_OP_WREN, 8'h00, 8);
            mem(t_a[i], t_e[i], t_ab[i]);
            rd(t_sr[i]);
        end
        bit_b <= 1'b1;
        cmd(fsr_pkg::FSR_OP_VWREN, 8'h00, 8);
        cmd(fsr_pkg::FSR_OP_WRSR, 8'hFC, 16);
        rd(8'h00);
        chk({6'h00, sch}, {6'h00, fsr_pkg::FSR_SCHEME_LOCK});
        bit_b <= 1'b0;
        cmd(fsr_pkg::FSR_OP_WREN, 8'h00, 8);
        arst_n_in <= 1'b0;
        repeat (3) @(posedge core_clk_in);
        arst_n_in <= 1'b1;
        repeat (8) @(posedge core_clk_in);
        chk(st, 8'h00);
        rd(8'h00);
        complete_run();
    end
endmodule
